// >>> design/fcl_pkg.sv
// Purpose: Shared constants for the configuration fuse loader
// Assumes: 200 MHz system clock, byte wide fuse store
// Notes: Offsets are byte indices of the fuse store
//
// Behaviour
// - Reset copies watchdog fuse bits 7:4 into watchdog window field.
// - Reset copies watchdog fuse bits 3:0 into watchdog period field.
// - Every brown-out fuse bit reaches its matching detector control field.
// - Fuse bits 7:5 load detector threshold level; codes above 3 reserved.
// - Fuse bit 4 picks sample rate: 0 is 128 Hz, 1 is 32 Hz.
// - Bits 3:2 set active mode: off, continuous, sampled, continuous with wake hold.
// - Bits 1:0 set sleep mode: off, continuous, sampled; code 3 reserved.
// - Oscillator field: 0 fast internal, 1 slow 32.768 kHz, others reserved.
// - Bits 7:6 pick flash check range: whole, boot, boot plus app, none.
// - Bit 5 picks flash check algorithm: 16-bit CCITT or 32-bit Ethernet.
// - Bits 3:2 set reset pin: 0 general input, 2 external reset.
// - Bit 0 set keeps EEPROM on chip erase; clear erases it.
// - Locked device always erases EEPROM on chip erase.
// - Start-up field gives no delay or 1 to 64 ms doubling.
// - Factory fuse contents are zero except first system fuse at 0xc0.
// - Fuse changes reach targets only after a following reset.

package fcl_pkg;

  // ---------------------------------------------------------------
  // Fuse store layout
  // ---------------------------------------------------------------
  localparam int FUSE_COUNT = 7;
  localparam logic [3:0] OFS_WATCHDOG = 4'h0;
  localparam logic [3:0] OFS_BROWNOUT = 4'h1;
  localparam logic [3:0] OFS_OSCILLATOR = 4'h2;
  localparam logic [3:0] OFS_SYSTEM_A = 4'h5;
  localparam logic [3:0] OFS_SYSTEM_B = 4'h6;

  // Writable bit masks, reserved bits kept at zero
  localparam logic [7:0] MASK_WATCHDOG = 8'hff;
  localparam logic [7:0] MASK_BROWNOUT = 8'hff;
  localparam logic [7:0] MASK_OSCILLATOR = 8'h0f;
  localparam logic [7:0] MASK_SYSTEM_A = 8'hed;
  localparam logic [7:0] MASK_SYSTEM_B = 8'h07;

  // Factory contents
  localparam logic [7:0] FACTORY_ZERO = 8'h00;
  localparam logic [7:0] FACTORY_SYSTEM_A = 8'hc0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int WD_WINDOW_LSB = 4;
  localparam int WD_PERIOD_LSB = 0;
  localparam int BO_LEVEL_LSB = 5;
  localparam int BO_RATE_BIT = 4;
  localparam int BO_ACTIVE_LSB = 2;
  localparam int BO_SLEEP_LSB = 0;
  localparam int OSC_SEL_LSB = 0;
  localparam int SA_RANGE_LSB = 6;
  localparam int SA_ALGO_BIT = 5;
  localparam int SA_RSTPIN_LSB = 2;
  localparam int SA_KEEP_BIT = 0;
  localparam int SB_STARTUP_LSB = 0;

  // ---------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------
  localparam logic [2:0] LEVEL_MAX_CODE = 3'h3;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_SAMPLED = 2'h2;
  localparam logic [1:0] MODE_CONT_WAKE_HOLD = 2'h3;
  localparam logic [3:0] OSC_FAST = 4'h0;
  localparam logic [3:0] OSC_SLOW = 4'h1;
  localparam logic [1:0] RANGE_NONE = 2'h3;
  localparam logic [1:0] RSTPIN_INPUT = 2'h0;
  localparam logic [1:0] RSTPIN_EXTERNAL = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STARTUP_UNIT_US = 1000;
  localparam int STARTUP_UNIT_CYCLES = (STARTUP_UNIT_US * 1000000) / CLK_PERIOD_PS;

  // Writable mask of a fuse offset, zero for reserved offsets
  function automatic logic [7:0] fuse_mask(input logic [3:0] ofs);
    case (ofs)
      OFS_WATCHDOG: fuse_mask = MASK_WATCHDOG;
      OFS_BROWNOUT: fuse_mask = MASK_BROWNOUT;
      OFS_OSCILLATOR: fuse_mask = MASK_OSCILLATOR;
      OFS_SYSTEM_A: fuse_mask = MASK_SYSTEM_A;
      OFS_SYSTEM_B: fuse_mask = MASK_SYSTEM_B;
      default: fuse_mask = 8'h00;
    endcase
  endfunction : fuse_mask

endpackage : fcl_pkg

// >>> design/fcl_store_if.sv
// Purpose: Carrier between loader core and fuse store
// Assumes: One clock domain
// Notes: Image holds all seven fuse bytes, offset 0 in lowest byte
`timescale 1ns/1ps

interface fcl_store_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [fcl_pkg::FUSE_COUNT-1:0][7:0] image;

  modport core (output wr_en, output wr_addr, output wr_data, input image);
  modport store (input wr_en, input wr_addr, input wr_data, output image);
endinterface : fcl_store_if

// >>> design/fcl_fuse_store.sv
// Purpose: Nonvolatile fuse byte store model
// Assumes: Power-on reset restores factory contents
// Notes: System reset leaves contents untouched
`timescale 1ns/1ps

module fcl_fuse_store (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic por_n,
  input wire logic ce,
  // Core side
  fcl_store_if.store bus
);

  logic [fcl_pkg::FUSE_COUNT-1:0][7:0] mem_q;

  // Factory load and masked programming writes
  always_ff @(posedge clk)
  begin
    if (!por_n)
    begin
      mem_q <= '0;
      mem_q[fcl_pkg::OFS_SYSTEM_A] <= fcl_pkg::FACTORY_SYSTEM_A;
    end
    else if (ce && bus.wr_en && (bus.wr_addr < 4'(fcl_pkg::FUSE_COUNT)))
    begin
      mem_q[bus.wr_addr[2:0]] <= bus.wr_data & fcl_pkg::fuse_mask(bus.wr_addr);
    end
  end

  assign bus.image = mem_q;

endmodule : fcl_fuse_store

// >>> design/fcl_startup_timer.sv
// Purpose: Start-up delay counter
// Assumes: Start is a one-cycle pulse
// Notes: Delay is unit times a power of two, code 0 gives none
`timescale 1ns/1ps

module fcl_startup_timer #(
  parameter int UNIT_CYCLES = fcl_pkg::STARTUP_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic [2:0] code,
  output logic done
);

  logic [31:0] cnt_q;
  logic busy_q;
  logic done_q;

  // Cycle count for a delay code
  function automatic logic [31:0] delay_cycles(input logic [2:0] c);
    if (c == 3'h0)
      delay_cycles = 32'h0;
    else
      delay_cycles = 32'(UNIT_CYCLES) << (c - 3'h1);
  endfunction : delay_cycles

  // Load on start, count down, flag completion
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (ce)
    begin
      if (start)
      begin
        if (delay_cycles(code) == 32'h0)
          done_q <= 1'b1;
        else
        begin
          cnt_q <= delay_cycles(code) - 32'h1;
          busy_q <= 1'b1;
          done_q <= 1'b0;
        end
      end
      else if (busy_q)
      begin
        if (cnt_q == 32'h0)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q - 32'h1;
      end
    end
  end

  assign done = done_q;

endmodule : fcl_startup_timer

// >>> design/fcl_loader.sv
// Purpose: Configuration fuse loader top
// Assumes: Inputs synchronous to clk; rst_n is the system reset
// Notes: Targets are captured only while rst_n is low
`timescale 1ns/1ps

module fcl_loader #(
  parameter int STARTUP_UNIT_CYCLES = fcl_pkg::STARTUP_UNIT_CYCLES
) (
  // Clock, resets and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic ce,
  // External programmer write port
  input wire logic prog_wr_en,
  input wire logic [3:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  output logic prog_refused,
  // Processor read port
  input wire logic cpu_rd_en,
  input wire logic [3:0] cpu_addr,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  // Lock state and chip erase
  input wire logic device_locked,
  input wire logic chip_erase_req,
  output logic eeprom_erase,
  // Watchdog control targets
  output logic [3:0] watchdog_window,
  output logic [3:0] watchdog_period,
  // Brown-out detector control targets
  output logic [2:0] brownout_threshold_level,
  output logic brownout_sample_rate,
  output logic [1:0] brownout_active_mode,
  output logic [1:0] brownout_sleep_mode,
  output logic brownout_wake_hold,
  // Clock source target
  output logic [3:0] default_oscillator_select,
  output logic osc_use_slow,
  // Flash integrity scanner targets
  output logic [1:0] flash_check_range,
  output logic flash_check_algorithm,
  output logic flash_check_start,
  // Reset pin and erase policy targets
  output logic [1:0] reset_pin_function,
  output logic reset_pin_ext_enable,
  output logic eeprom_keep_on_erase,
  // Start-up sequencing
  output logic [2:0] startup_delay_select,
  output logic exec_ready,
  output logic reserved_code_seen
);

  // ---------------------------------------------------------------
  // Types and storage
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FCL_ST_LOAD = 2'b00,
    FCL_ST_WAIT = 2'b01,
    FCL_ST_RUN = 2'b10
  } fcl_state_t;

  fcl_state_t state_q;
  fcl_state_t state_d;

  fcl_store_if store_bus ();

  logic [7:0] wd_q;
  logic [7:0] bo_q;
  logic [7:0] osc_q;
  logic [7:0] sa_q;
  logic [7:0] sb_q;
  logic [7:0] cpu_rdata_q;
  logic cpu_rvalid_q;
  logic prog_refused_q;
  logic eeprom_erase_q;
  logic flash_start_q;
  logic reserved_q;
  logic timer_start;
  logic timer_done;

  // Byte of the live store at an offset, zero where reserved
  function automatic logic [7:0] live_byte(
    input logic [fcl_pkg::FUSE_COUNT-1:0][7:0] img,
    input logic [3:0] ofs
  );
    if (ofs < 4'(fcl_pkg::FUSE_COUNT))
      live_byte = img[ofs[2:0]] & fcl_pkg::fuse_mask(ofs);
    else
      live_byte = 8'h00;
  endfunction : live_byte

  // ---------------------------------------------------------------
  // Fuse store and start-up timer
  // ---------------------------------------------------------------
  fcl_fuse_store u_store (
    .clk(clk),
    .por_n(por_n),
    .ce(ce),
    .bus(store_bus)
  );

  fcl_startup_timer #(
    .UNIT_CYCLES(STARTUP_UNIT_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(timer_start),
    .code(startup_delay_select),
    .done(timer_done)
  );

  // ---------------------------------------------------------------
  // Programmer write path
  // ---------------------------------------------------------------
  // Only the programmer port reaches the store, and not while locked
  assign store_bus.wr_en = prog_wr_en && !device_locked;
  assign store_bus.wr_addr = prog_addr;
  assign store_bus.wr_data = prog_wdata;

  // Refusal pulse for writes tried while locked
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prog_refused_q <= 1'b0;
    else if (ce)
      prog_refused_q <= prog_wr_en && device_locked;
  end

  // ---------------------------------------------------------------
  // Processor read path
  // ---------------------------------------------------------------
  // Reads see the live store; there is no write path from this side
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cpu_rdata_q <= 8'h00;
      cpu_rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      cpu_rvalid_q <= cpu_rd_en;
      if (cpu_rd_en)
        cpu_rdata_q <= live_byte(store_bus.image, cpu_addr);
    end
  end

  // ---------------------------------------------------------------
  // Reset time capture
  // ---------------------------------------------------------------
  // Snapshot follows the store only while reset is held
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wd_q <= live_byte(store_bus.image, fcl_pkg::OFS_WATCHDOG);
      bo_q <= live_byte(store_bus.image, fcl_pkg::OFS_BROWNOUT);
      osc_q <= live_byte(store_bus.image, fcl_pkg::OFS_OSCILLATOR);
      sa_q <= live_byte(store_bus.image, fcl_pkg::OFS_SYSTEM_A);
      sb_q <= live_byte(store_bus.image, fcl_pkg::OFS_SYSTEM_B);
    end
  end
  // Snapshot holds from release to next reset, whatever is written

  // ---------------------------------------------------------------
  // Field distribution
  // ---------------------------------------------------------------
  // Watchdog control fields
  assign watchdog_window = wd_q[fcl_pkg::WD_WINDOW_LSB +: 4];
  assign watchdog_period = wd_q[fcl_pkg::WD_PERIOD_LSB +: 4];

  // Brown-out detector control fields
  assign brownout_threshold_level = bo_q[fcl_pkg::BO_LEVEL_LSB +: 3];
  assign brownout_sample_rate = bo_q[fcl_pkg::BO_RATE_BIT];
  assign brownout_active_mode = bo_q[fcl_pkg::BO_ACTIVE_LSB +: 2];
  assign brownout_sleep_mode = bo_q[fcl_pkg::BO_SLEEP_LSB +: 2];
  assign brownout_wake_hold = (brownout_active_mode == fcl_pkg::MODE_CONT_WAKE_HOLD);

  // Clock source fields
  assign default_oscillator_select = osc_q[fcl_pkg::OSC_SEL_LSB +: 4];
  assign osc_use_slow = (default_oscillator_select == fcl_pkg::OSC_SLOW);

  // Flash scanner fields
  assign flash_check_range = sa_q[fcl_pkg::SA_RANGE_LSB +: 2];
  assign flash_check_algorithm = sa_q[fcl_pkg::SA_ALGO_BIT];
  assign flash_check_start = flash_start_q;

  // Reset pin and erase policy fields
  assign reset_pin_function = sa_q[fcl_pkg::SA_RSTPIN_LSB +: 2];
  assign reset_pin_ext_enable = (reset_pin_function == fcl_pkg::RSTPIN_EXTERNAL);
  assign eeprom_keep_on_erase = sa_q[fcl_pkg::SA_KEEP_BIT];

  // Start-up field
  assign startup_delay_select = sb_q[fcl_pkg::SB_STARTUP_LSB +: 3];

  // ---------------------------------------------------------------
  // Reserved code detection
  // ---------------------------------------------------------------
  // Flags any captured field holding a reserved code
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reserved_q <= 1'b0;
    else if (ce)
    begin
      reserved_q <= (brownout_threshold_level > fcl_pkg::LEVEL_MAX_CODE)
        || (brownout_sleep_mode == fcl_pkg::MODE_CONT_WAKE_HOLD)
        || (default_oscillator_select > fcl_pkg::OSC_SLOW)
        || (reset_pin_function[0]);
    end
  end

  // ---------------------------------------------------------------
  // Chip erase handling
  // ---------------------------------------------------------------
  // Erase pulse unless keep is set and the device is unlocked
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      eeprom_erase_q <= 1'b0;
    else if (ce)
      eeprom_erase_q <= chip_erase_req && (device_locked || !eeprom_keep_on_erase);
  end

  // ---------------------------------------------------------------
  // Start-up sequencer
  // ---------------------------------------------------------------
  // Next state
  always_comb
  begin
    state_d = state_q;
    timer_start = 1'b0;
    case (state_q)
      FCL_ST_LOAD:
      begin
        timer_start = 1'b1;
        state_d = FCL_ST_WAIT;
      end
      FCL_ST_WAIT:
      begin
        if (timer_done)
          state_d = FCL_ST_RUN;
      end
      FCL_ST_RUN:
      begin
        state_d = FCL_ST_RUN;
      end
      default:
      begin
        state_d = FCL_ST_LOAD;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= FCL_ST_LOAD;
    else if (ce)
      state_q <= state_d;
  end

  // Scanner start pulse on leaving the load state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flash_start_q <= 1'b0;
    else if (ce)
      flash_start_q <= (state_q == FCL_ST_LOAD) && (flash_check_range != fcl_pkg::RANGE_NONE);
  end

  // ---------------------------------------------------------------
  // Output drive
  // ---------------------------------------------------------------
  assign exec_ready = (state_q == FCL_ST_RUN);
  assign reserved_code_seen = reserved_q;
  assign eeprom_erase = eeprom_erase_q;
  assign prog_refused = prog_refused_q;
  assign cpu_rdata = cpu_rdata_q;
  assign cpu_rvalid = cpu_rvalid_q;

endmodule : fcl_loader

// >>> test/fcl_target_model.sv
// Purpose: Model of the control registers fed by the loader
// Assumes: Targets settle before execution starts
// Notes: Images freeze once exec_ready is high
`timescale 1ns/1ps

module fcl_target_model (
  // Clock and status
  input wire logic clk,
  input wire logic exec_ready,
  // Loader targets
  input wire logic [3:0] watchdog_window,
  input wire logic [3:0] watchdog_period,
  input wire logic [2:0] brownout_threshold_level,
  input wire logic brownout_sample_rate,
  input wire logic [1:0] brownout_active_mode,
  input wire logic [1:0] brownout_sleep_mode,
  // Control register images
  output logic [7:0] wd_ctrl_q,
  output logic [7:0] bo_ctrl_q
);
  // Registers follow the loader until code runs
  always_ff @(posedge clk)
  begin
    if (!exec_ready)
    begin
      wd_ctrl_q <= {watchdog_window, watchdog_period};
      bo_ctrl_q <= {brownout_threshold_level, brownout_sample_rate,
        brownout_active_mode, brownout_sleep_mode};
    end
  end
endmodule : fcl_target_model

// >>> test/fcl_loader_assertions.sv
// Purpose: Port checker for the fuse loader
// Assumes: One clock, rst_n synchronous active low
// Notes: Attached by bind from the bench
`timescale 1ns/1ps

module fcl_loader_assertions #(
  parameter int STARTUP_UNIT_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Requests
  input wire logic prog_wr_en,
  input wire logic cpu_rd_en,
  input wire logic device_locked,
  input wire logic chip_erase_req,
  // Answers
  input wire logic prog_refused,
  input wire logic cpu_rvalid,
  input wire logic eeprom_erase,
  // Targets
  input wire logic [3:0] watchdog_window,
  input wire logic [3:0] watchdog_period,
  input wire logic [1:0] brownout_active_mode,
  input wire logic brownout_wake_hold,
  input wire logic [3:0] default_oscillator_select,
  input wire logic osc_use_slow,
  input wire logic [1:0] flash_check_range,
  input wire logic flash_check_start,
  input wire logic [1:0] reset_pin_function,
  input wire logic reset_pin_ext_enable,
  input wire logic eeprom_keep_on_erase,
  input wire logic exec_ready
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_targets_steady: assert property (
    exec_ready && $past(exec_ready) |-> $stable({watchdog_window, watchdog_period}))
    else $error("targets moved while running");
  a_wake_hold: assert property (
    brownout_wake_hold == (brownout_active_mode == 2'h3))
    else $error("wake hold decode wrong");
  a_osc_slow: assert property (
    osc_use_slow == (default_oscillator_select == 4'h1))
    else $error("slow oscillator decode wrong");
  a_pin_ext: assert property (
    reset_pin_ext_enable == (reset_pin_function == 2'h2))
    else $error("reset pin decode wrong");
  a_erase_locked: assert property (
    ce && chip_erase_req && device_locked |=> eeprom_erase)
    else $error("locked erase kept memory");
  a_erase_keep: assert property (
    ce && chip_erase_req && !device_locked |=> eeprom_erase == !$past(eeprom_keep_on_erase))
    else $error("erase policy wrong");
  a_read_answer: assert property (
    cpu_rvalid == $past(ce && cpu_rd_en))
    else $error("read answer timing wrong");
  a_write_refused: assert property (
    prog_refused == $past(ce && prog_wr_en && device_locked))
    else $error("refusal timing wrong");
  a_scan_start: assert property (
    flash_check_start |-> flash_check_range != 2'h3 && !$past(exec_ready))
    else $error("flash scan started wrongly");

  c_locked_erase: cover property (device_locked && eeprom_erase);
  c_scan_start: cover property (flash_check_start);
  c_wake_hold: cover property (brownout_wake_hold && exec_ready);
endmodule : fcl_loader_assertions

// >>> test/fcl_loader_tb.sv
// Purpose: Self-checking bench for the fuse loader
// Assumes: Short start-up unit, clock enable held high except for one erase
// Notes: Read answers are checked from a queue by a watcher
`timescale 1ns/1ps

module fcl_loader_tb;
  localparam int UNIT = 4;
  localparam logic [7:0] MASK [7] = '{8'hff, 8'hff, 8'h0f, 8'h00, 8'h00, 8'hed, 8'h07};
  logic clk, rst_n, por_n, ce, prog_wr_en, cpu_rd_en, device_locked, chip_erase_req;
  logic prog_refused, cpu_rvalid, eeprom_erase, exec_ready, algo, keep;
  logic [3:0] prog_addr, cpu_addr, wd_win, wd_per, osc_sel;
  logic [7:0] prog_wdata, cpu_rdata, wd_img, bo_img, v;
  logic [2:0] bo_level, startup_sel;
  logic bo_rate, rsv, rsv_exp, scan;
  logic [1:0] bo_act, bo_slp, range, pin;
  logic [7:0] fuse [7];
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'h32;
  int miscompares = 0;
  int total_checks = 0;

  // ---------------------------------------------------------------
  // Clock, design and far side
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  fcl_loader #(.STARTUP_UNIT_CYCLES(UNIT)) fcl_loader_i (.clk(clk), .rst_n(rst_n),
    .por_n(por_n), .ce(ce), .prog_wr_en(prog_wr_en), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_refused(prog_refused), .cpu_rd_en(cpu_rd_en),
    .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .device_locked(device_locked), .chip_erase_req(chip_erase_req),
    .eeprom_erase(eeprom_erase), .watchdog_window(wd_win), .watchdog_period(wd_per),
    .brownout_threshold_level(bo_level), .brownout_sample_rate(bo_rate),
    .brownout_active_mode(bo_act), .brownout_sleep_mode(bo_slp), .brownout_wake_hold(),
    .default_oscillator_select(osc_sel), .osc_use_slow(), .flash_check_range(range),
    .flash_check_algorithm(algo), .flash_check_start(scan), .reset_pin_function(pin),
    .reset_pin_ext_enable(), .eeprom_keep_on_erase(keep),
    .startup_delay_select(startup_sel), .exec_ready(exec_ready), .reserved_code_seen(rsv));

  fcl_target_model fcl_target_model_i (.clk(clk), .exec_ready(exec_ready),
    .watchdog_window(wd_win), .watchdog_period(wd_per), .brownout_threshold_level(bo_level),
    .brownout_sample_rate(bo_rate), .brownout_active_mode(bo_act),
    .brownout_sleep_mode(bo_slp), .wd_ctrl_q(wd_img), .bo_ctrl_q(bo_img));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_cycles(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp)
    begin
      miscompares++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cycles

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // Programmer writes only defined bits
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    prog_wr_en = 1'b1;
    prog_addr = a;
    prog_wdata = d;
    @(negedge clk);
    prog_wr_en = 1'b0;
    chk("refused", {7'h0, device_locked}, {7'h0, prog_refused});
    if (!device_locked && a < 7)
      fuse[a] = d & MASK[a];
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    cpu_rd_en = 1'b1;
    cpu_addr = a;
    exp_q.push_back(a < 7 ? fuse[a] : 8'h00);
    @(negedge clk);
    cpu_rd_en = 1'b0;
  endtask : rd

  task automatic erase(input logic exp);
    @(negedge clk);
    chip_erase_req = 1'b1;
    @(negedge clk);
    chip_erase_req = 1'b0;
    chk("erase", {7'h0, exp}, {7'h0, eeprom_erase});
  endtask : erase

  // Reset, time the start-up and compare every captured fuse field
  task automatic reset_run(input logic por);
    int n;
    int want;
    @(negedge clk);
    rst_n = 1'b0;
    por_n = ~por;
    @(negedge clk);
    por_n = 1'b1;
    repeat (9) @(negedge clk);
    rst_n = 1'b1;
    if (por)
      fuse = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00};
    want = 2 + (fuse[6][2:0] == 3'h0 ? 0 : UNIT << (fuse[6][2:0] - 1));
    n = 0;
    while (exec_ready !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
      if (n == 1)
        chk("scan start", {7'h0, (fuse[5][7:6] != 2'h3)}, {7'h0, scan});
    end
    chk_cycles("startup", want, n);
    if (n >= 400)
      give_verdict();
    chk("watchdog", fuse[0], wd_img);
    chk("brownout", fuse[1], bo_img);
    chk("oscillator", fuse[2], {4'h0, osc_sel});
    chk("system a", fuse[5], {range, algo, 1'b0, pin, 1'b0, keep});
    chk("system b", fuse[6], {5'h0, startup_sel});
    rsv_exp = (fuse[1][7:5] > 3'h3) || (fuse[1][1:0] == 2'h3) || (fuse[2][3:0] > 4'h1)
      || fuse[5][2];
    chk("reserved", {7'h0, rsv_exp}, {7'h0, rsv});
  endtask : reset_run

  // Watcher pairs each read answer with the oldest note
  always @(negedge clk)
  begin
    if (cpu_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("read count", 8'h01, 8'h00);
      else
        chk("read data", exp_q.pop_front(), cpu_rdata);
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    #400000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    {rst_n, por_n, prog_wr_en, cpu_rd_en, device_locked, chip_erase_req} = '0;
    ce = 1'b1;
    prog_addr = 4'h0;
    prog_wdata = 8'h00;
    cpu_addr = 4'h0;
    reset_run(1'b1);
    for (int a = 0; a < 8; a++)
      rd(a[3:0]);
    $display("factory contents done");
    for (int i = 0; i < 8; i++)
    begin
      v = rnd();
      wr(4'h0, v);
      wr(4'h1, {v[7:4], i[1:0], i[1:0]});
      wr(4'h2, {4'h0, i[3:0]});
      wr(4'h5, {i[1:0], v[5:0]} & MASK[5]);
      wr(4'h6, {5'h0, i[2:0]});
      wr(4'h8, v);
      for (int a = 0; a < 8; a++)
        rd(a[3:0]);
      chk("held", wd_img, {wd_win, wd_per});
      reset_run(1'b0);
    end
    $display("field loading done");
    wr(4'h5, 8'h01);
    reset_run(1'b0);
    erase(1'b0);
    @(negedge clk);
    device_locked = 1'b1;
    erase(1'b1);
    wr(4'h0, ~fuse[0]);
    rd(4'h0);
    @(negedge clk);
    device_locked = 1'b0;
    wr(4'h5, 8'h00);
    reset_run(1'b0);
    erase(1'b1);
    @(negedge clk);
    ce = 1'b0;
    erase(1'b0);
    ce = 1'b1;
    $display("erase and lock done");
    repeat (3) @(negedge clk);
    chk("reads left", 8'h00, exp_q.size());
    give_verdict();
  end
endmodule : fcl_loader_tb

bind fcl_loader fcl_loader_assertions #(.STARTUP_UNIT_CYCLES(STARTUP_UNIT_CYCLES))
  fcl_loader_assertions_i (.clk(clk), .rst_n(rst_n), .ce(ce), .prog_wr_en(prog_wr_en),
  .cpu_rd_en(cpu_rd_en), .device_locked(device_locked), .chip_erase_req(chip_erase_req),
  .prog_refused(prog_refused), .cpu_rvalid(cpu_rvalid), .eeprom_erase(eeprom_erase),
  .watchdog_window(watchdog_window), .watchdog_period(watchdog_period),
  .brownout_active_mode(brownout_active_mode), .brownout_wake_hold(brownout_wake_hold),
  .default_oscillator_select(default_oscillator_select), .osc_use_slow(osc_use_slow),
  .flash_check_range(flash_check_range), .flash_check_start(flash_check_start),
  .reset_pin_function(reset_pin_function), .reset_pin_ext_enable(reset_pin_ext_enable),
  .eeprom_keep_on_erase(eeprom_keep_on_erase), .exec_ready(exec_ready));
